// [rtl/mmsm_map.v]
// Memory spaces, data window and data-space register bank of the core.
// Operation
// - Program, data and stack storage are separate spaces with own paths.
// - Fetch uses a 12-bit instruction pointer reaching 4K bytes.
// - Return stack holds six 12-bit entries for calls and interrupts.
// - Read-out protection set blocks all external program memory reads.
// - Protection clears by a full erase wiping all program memory, or after reset, in both cases only while the read-protect option is clear.
// - A 64-byte data region reads constants from program memory.
// - Window is data 40h to 7Fh, block chosen by six-bit select.
// - Data space decodes RAM, core, port, peripheral and option registers.
// - After reset every port pin is input with pull-up until changed.
// - Port data, direction and option registers are read/write, reset 0.
// - Interrupt option register is write-only, decoded at C8h.
// - Converter result is read-only; control resets 40h, mixed access.
// - Timer prescale, count and status reset to 7Fh, FFh and 00h.
// - Port data reads return pins for inputs, stored value for outputs.
`timescale 1ns/100ps
`include "mmsm_defines.vh"
module mmsm_map #(
  parameter PW = 8
) (
  // Clock and reset.
  input  wire                  sys_clk,
  input  wire                  nrst,
  // Instruction pointer and return stack.
  input  wire                  ipStep,
  input  wire                  ipJump,
  input  wire                  ipCall,
  input  wire                  ipRet,
  input  wire [`MMSM_IP_W-1:0] ipTarget,
  output wire [`MMSM_IP_W-1:0] instructionPointer,
  output reg  [7:0]            fetchData,
  output wire [2:0]            stackLevel,
  // Data space access.
  input  wire [7:0]            dataAddr,
  input  wire                  dataWrEn,
  input  wire                  dataRdEn,
  input  wire [7:0]            dataWrData,
  output reg  [7:0]            dataRdData,
  // External program memory access.
  input  wire                  extRdEn,
  input  wire [`MMSM_IP_W-1:0] extAddr,
  output reg  [7:0]            extRdData,
  output reg                   extRdValid,
  output reg                   extRefused,
  input  wire                  progWrEn,
  input  wire [`MMSM_IP_W-1:0] progAddr,
  input  wire [7:0]            progWrData,
  input  wire                  protectSet,
  input  wire                  optReadProtect,
  input  wire                  eraseStart,
  output wire                  eraseBusy,
  output wire                  readProtected,
  // Port pins.
  input  wire [PW-1:0]         portAPinIn,
  output wire [PW-1:0]         portAPinOut,
  output wire [PW-1:0]         portAPinOe,
  output wire [PW-1:0]         portAPullUp,
  input  wire [PW-1:0]         portBPinIn,
  output wire [PW-1:0]         portBPinOut,
  output wire [PW-1:0]         portBPinOe,
  output wire [PW-1:0]         portBPullUp,
  // Peripheral register faces.
  input  wire [7:0]            converterResult,
  input  wire [7:0]            converterStatus,
  output wire [7:0]            converterControl,
  output wire [7:0]            interruptOption,
  output wire [7:0]            timerPrescale,
  output wire [7:0]            timerDowncount,
  output wire [7:0]            timerStatusControl,
  output wire [7:0]            watchdogCounter
);

  localparam IPW = `MMSM_IP_W;
  localparam SD  = `MMSM_STACK_DEPTH;
  localparam [IPW-1:0] IP_ONE  = 12'h001;
  localparam [IPW-1:0] IP_LAST = 12'hFFF;

  //////////////////////////////////////////////////////////////////////////
  // Instruction pointer and six-entry return stack.

  reg  [IPW-1:0] ip_reg;
  reg  [IPW-1:0] ip_next;
  reg  [2:0]     level_reg;
  reg  [2:0]     level_next;
  wire [IPW-1:0] stackTop;
  wire [IPW-1:0] ipPlus = ip_reg + IP_ONE;

  always @* begin
    ip_next    = ip_reg;
    level_next = level_reg;
    if (ipCall) begin
      ip_next = ipTarget;
      if (level_reg != SD[2:0]) begin
        level_next = level_reg + 3'd1;
      end
    end else if (ipRet) begin
      ip_next = stackTop;
      if (level_reg != 3'd0) begin
        level_next = level_reg - 3'd1;
      end
    end else if (ipJump) begin
      ip_next = ipTarget;
    end else if (ipStep) begin
      ip_next = ipPlus;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ip_reg    <= IP_LAST;
      level_reg <= 3'd0;
    end else begin
      ip_reg    <= ip_next;
      level_reg <= level_next;
    end
  end

  // A push beyond six levels drops the oldest address, as a shift stack does.
  genvar s;
  generate
    for (s = 0; s < SD; s = s + 1) begin : g_stack
      reg  [IPW-1:0] entry_reg;
      wire [IPW-1:0] pushIn;
      wire [IPW-1:0] popIn;
      if (s == 0) begin : g_top
        assign pushIn = ipPlus;
      end else begin : g_below
        assign pushIn = g_stack[s-1].entry_reg;
      end
      if (s == SD-1) begin : g_bottom
        assign popIn = {IPW{1'b0}};
      end else begin : g_above
        assign popIn = g_stack[s+1].entry_reg;
      end
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          entry_reg <= {IPW{1'b0}};
        end else if (ipCall) begin
          entry_reg <= pushIn;
        end else if (ipRet) begin
          entry_reg <= popIn;
        end
      end
    end
  endgenerate

  assign stackTop           = g_stack[0].entry_reg;
  assign instructionPointer = ip_reg;
  assign stackLevel         = level_reg;

  //////////////////////////////////////////////////////////////////////////
  // Read-out protection and full erase.

  reg            prot_reg;
  reg  [1:0]     protLoaded_reg;
  reg            optSync1_reg;
  reg            optSync2_reg;
  reg            erase_reg;
  reg  [IPW-1:0] eraseCnt_reg;
  wire           eraseDone = erase_reg & (eraseCnt_reg == IP_LAST);

  // The cell starts locked so a reset cannot unlock it before the option has been loaded.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      optSync1_reg   <= 1'b0;
      optSync2_reg   <= 1'b0;
      prot_reg       <= 1'b1;
      protLoaded_reg <= 2'b00;
      erase_reg      <= 1'b0;
      eraseCnt_reg   <= {IPW{1'b0}};
    end else begin
      optSync1_reg   <= optReadProtect;
      optSync2_reg   <= optSync1_reg;
      if (protLoaded_reg != 2'b11) begin
        protLoaded_reg <= protLoaded_reg + 2'b01;
      end
      // The option is taken only once it has passed both flops; until then
      // the cell stays locked, so no read slips through just after reset.
      if (protectSet | optSync2_reg) begin
        prot_reg <= 1'b1;
      end else if (eraseDone) begin
        prot_reg <= 1'b0;
      end else if (protLoaded_reg == 2'b10) begin
        prot_reg <= optSync2_reg;
      end
      if (eraseStart & !erase_reg) begin
        erase_reg    <= 1'b1;
        eraseCnt_reg <= {IPW{1'b0}};
      end else if (erase_reg) begin
        eraseCnt_reg <= eraseCnt_reg + IP_ONE;
        if (eraseDone) begin
          erase_reg <= 1'b0;
        end
      end
    end
  end

  assign eraseBusy     = erase_reg;
  assign readProtected = prot_reg;

  //////////////////////////////////////////////////////////////////////////
  // Program memory: port A fetches, port B serves window and readback.

  reg  [`MMSM_SEL_W-1:0] winSel_reg;
  wire                   winHit = (dataAddr[7:6] == `MMSM_WIN_BASE);
  wire                   winRd  = dataRdEn & winHit;
  wire                   extGo  = extRdEn & !winRd & !prot_reg & !erase_reg;
  wire [IPW-1:0]         winAddr = {winSel_reg, dataAddr[5:0]};
  wire [IPW-1:0]         portBAddr = winRd ? winAddr : extAddr;
  wire                   pmWr = erase_reg | progWrEn;
  wire [IPW-1:0]         pmWrAddr = erase_reg ? eraseCnt_reg : progAddr;
  wire [7:0]             pmWrData = erase_reg ? `MMSM_ERASED : progWrData;
  wire [7:0]             pmDataA;
  wire [7:0]             pmDataB;

  mmsm_mem #(
    .AW (IPW),
    .DW (8)
  ) u_prog_mem (
    .sys_clk (sys_clk),
    .wrEn    (pmWr),
    .wrAddr  (pmWrAddr),
    .wrData  (pmWrData),
    .rdAddrA (ip_reg),
    .rdDataA (pmDataA),
    .rdAddrB (portBAddr),
    .rdDataB (pmDataB)
  );

  reg extGo_reg;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      extGo_reg  <= 1'b0;
      extRdValid <= 1'b0;
      extRefused <= 1'b0;
    end else begin
      extGo_reg  <= extGo;
      extRdValid <= extGo;
      extRefused <= extRdEn & !extGo;
    end
  end

  always @* begin
    fetchData = pmDataA;
    extRdData = extGo_reg ? pmDataB : 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // User RAM, a space of its own next to program memory.

  wire       ramHit = (dataAddr[7:6] == `MMSM_RAM_BASE);
  wire [7:0] ramData;

  mmsm_mem #(
    .AW (6),
    .DW (8)
  ) u_data_ram (
    .sys_clk (sys_clk),
    .wrEn    (dataWrEn & ramHit),
    .wrAddr  (dataAddr[5:0]),
    .wrData  (dataWrData),
    .rdAddrA (dataAddr[5:0]),
    .rdDataA (ramData),
    .rdAddrB (6'h00),
    .rdDataB ()
  );

  //////////////////////////////////////////////////////////////////////////
  // Core, port and peripheral registers.

  reg [7:0] idx_reg [0:3];
  reg [7:0] accum_reg;
  reg [7:0] paData_reg;
  reg [7:0] pbData_reg;
  reg [7:0] paDir_reg;
  reg [7:0] pbDir_reg;
  reg [7:0] paOpt_reg;
  reg [7:0] pbOpt_reg;
  reg [7:0] intOpt_reg;
  reg [7:0] cnvCtrl_reg;
  reg [7:0] cnvStat_reg;
  reg [7:0] psc_reg;
  reg [7:0] cnt_reg;
  reg [7:0] stc_reg;
  reg [7:0] wdg_reg;
  wire      idxHit = (dataAddr[7:2] == `MMSM_IDX_BASE);

  function wr;
    input [7:0] off;
    begin
      wr = dataWrEn & (dataAddr == off);
    end
  endfunction

  // Index, accumulator, window and interrupt option registers keep no reset value.
  always @(posedge sys_clk) begin
    if (dataWrEn & idxHit) begin
      idx_reg[dataAddr[1:0]] <= dataWrData;
    end
    if (wr(`MMSM_ACCUM)) begin
      accum_reg <= dataWrData;
    end
    if (wr(`MMSM_INT_OPT)) begin
      intOpt_reg <= dataWrData;
    end
    if (wr(`MMSM_WIN_SEL)) begin
      winSel_reg <= dataWrData[`MMSM_SEL_W-1:0];
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      paData_reg  <= `MMSM_PORT_RST;
      pbData_reg  <= `MMSM_PORT_RST;
      paDir_reg   <= `MMSM_PORT_RST;
      pbDir_reg   <= `MMSM_PORT_RST;
      paOpt_reg   <= `MMSM_PORT_RST;
      pbOpt_reg   <= `MMSM_PORT_RST;
      cnvCtrl_reg <= `MMSM_CNV_RST;
      cnvStat_reg <= `MMSM_CNV_RST;
      psc_reg     <= `MMSM_PSC_RST;
      cnt_reg     <= `MMSM_CNT_RST;
      stc_reg     <= `MMSM_STC_RST;
      wdg_reg     <= `MMSM_WDG_RST;
    end else begin
      cnvStat_reg <= converterStatus;
      if (wr(`MMSM_PA_DATA)) paData_reg <= dataWrData;
      if (wr(`MMSM_PB_DATA)) pbData_reg <= dataWrData;
      if (wr(`MMSM_PA_DIR)) paDir_reg <= dataWrData;
      if (wr(`MMSM_PB_DIR)) pbDir_reg <= dataWrData;
      if (wr(`MMSM_PA_OPT)) paOpt_reg <= dataWrData;
      if (wr(`MMSM_PB_OPT)) pbOpt_reg <= dataWrData;
      if (wr(`MMSM_CNV_CTRL)) cnvCtrl_reg <= dataWrData;
      if (wr(`MMSM_TMR_PSC)) psc_reg <= dataWrData;
      if (wr(`MMSM_TMR_CNT)) cnt_reg <= dataWrData;
      if (wr(`MMSM_TMR_STC)) stc_reg <= dataWrData;
      if (wr(`MMSM_WDG_CNT)) wdg_reg <= dataWrData;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Port pins: zero direction and option give input with pull-up.

  reg [PW-1:0] paSync1_reg;
  reg [PW-1:0] paSync2_reg;
  reg [PW-1:0] pbSync1_reg;
  reg [PW-1:0] pbSync2_reg;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      paSync1_reg <= {PW{1'b0}};
      paSync2_reg <= {PW{1'b0}};
      pbSync1_reg <= {PW{1'b0}};
      pbSync2_reg <= {PW{1'b0}};
    end else begin
      paSync1_reg <= portAPinIn;
      paSync2_reg <= paSync1_reg;
      pbSync1_reg <= portBPinIn;
      pbSync2_reg <= pbSync1_reg;
    end
  end

  assign portAPinOut = paData_reg[PW-1:0];
  assign portBPinOut = pbData_reg[PW-1:0];
  assign portAPinOe  = paDir_reg[PW-1:0];
  assign portBPinOe  = pbDir_reg[PW-1:0];
  assign portAPullUp = ~paDir_reg[PW-1:0] & ~paOpt_reg[PW-1:0];
  assign portBPullUp = ~pbDir_reg[PW-1:0] & ~pbOpt_reg[PW-1:0];

  wire [7:0] paView = (paDir_reg & paData_reg) | (~paDir_reg & paSync2_reg);
  wire [7:0] pbView = (pbDir_reg & pbData_reg) | (~pbDir_reg & pbSync2_reg);

  assign converterControl   = cnvCtrl_reg;
  assign interruptOption    = intOpt_reg;
  assign timerPrescale      = psc_reg;
  assign timerDowncount     = cnt_reg;
  assign timerStatusControl = stc_reg;
  assign watchdogCounter    = wdg_reg;

  //////////////////////////////////////////////////////////////////////////
  // Read path: one cycle from request to data for every location.

  reg [7:0] regRd_next;
  reg [7:0] regRd_reg;
  reg       winRd_reg;
  reg       ramRd_reg;

  always @* begin
    regRd_next = 8'h00;
    if (idxHit) begin
      regRd_next = idx_reg[dataAddr[1:0]];
    end else begin
      case (dataAddr)
        `MMSM_PA_DATA:  regRd_next = paView;
        `MMSM_PB_DATA:  regRd_next = pbView;
        `MMSM_PA_DIR:   regRd_next = paDir_reg;
        `MMSM_PB_DIR:   regRd_next = pbDir_reg;
        `MMSM_PA_OPT:   regRd_next = paOpt_reg;
        `MMSM_PB_OPT:   regRd_next = pbOpt_reg;
        `MMSM_CNV_RES:  regRd_next = converterResult;
        `MMSM_CNV_CTRL: regRd_next = (cnvCtrl_reg & ~`MMSM_CNV_RO &
                                      ~`MMSM_CNV_WO) |
                                     (cnvStat_reg & `MMSM_CNV_RO);
        `MMSM_TMR_PSC:  regRd_next = psc_reg;
        `MMSM_TMR_CNT:  regRd_next = cnt_reg;
        `MMSM_TMR_STC:  regRd_next = stc_reg;
        `MMSM_WDG_CNT:  regRd_next = wdg_reg;
        `MMSM_ACCUM:    regRd_next = accum_reg;
        default:        regRd_next = 8'h00;
      endcase
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRd_reg <= 8'h00;
      winRd_reg <= 1'b0;
      ramRd_reg <= 1'b0;
    end else begin
      regRd_reg <= regRd_next;
      winRd_reg <= winRd;
      ramRd_reg <= dataRdEn & ramHit;
    end
  end

  always @* begin
    if (winRd_reg) begin
      dataRdData = pmDataB;
    end else if (ramRd_reg) begin
      dataRdData = ramData;
    end else begin
      dataRdData = regRd_reg;
    end
  end

endmodule // mmsm_map

// [rtl/mmsm_defines.vh]
// Offsets, field positions, reset values and counts of the memory map.
`ifndef MMSM_DEFINES_VH
`define MMSM_DEFINES_VH
`define MMSM_IP_W        12
`define MMSM_STACK_DEPTH 6
`define MMSM_WIN_BASE    2'b01
`define MMSM_RAM_BASE    2'b00
`define MMSM_IDX_BASE    6'h20
`define MMSM_PA_DATA     8'hC0
`define MMSM_PB_DATA     8'hC1
`define MMSM_PA_DIR      8'hC4
`define MMSM_PB_DIR      8'hC5
`define MMSM_INT_OPT     8'hC8
`define MMSM_WIN_SEL     8'hC9
`define MMSM_PA_OPT      8'hCC
`define MMSM_PB_OPT      8'hCD
`define MMSM_CNV_RES     8'hD0
`define MMSM_CNV_CTRL    8'hD1
`define MMSM_TMR_PSC     8'hD2
`define MMSM_TMR_CNT     8'hD3
`define MMSM_TMR_STC     8'hD4
`define MMSM_WDG_CNT     8'hD8
`define MMSM_ACCUM       8'hFF
`define MMSM_PORT_RST    8'h00
`define MMSM_CNV_RST     8'h40
`define MMSM_CNV_RO      8'h40
`define MMSM_CNV_WO      8'h30
`define MMSM_PSC_RST     8'h7F
`define MMSM_CNT_RST     8'hFF
`define MMSM_STC_RST     8'h00
`define MMSM_WDG_RST     8'hFE
`define MMSM_ERASED      8'hFF
`define MMSM_SEL_W       6
`endif

// [rtl/mmsm_mem.v]
// Single-write, dual-read memory with registered read data.
`timescale 1ns/100ps
module mmsm_mem #(
  parameter AW = 12,
  parameter DW = 8
) (
  // Clock.
  input  wire          sys_clk,
  // Write port.
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  // Read port A.
  input  wire [AW-1:0] rdAddrA,
  output reg  [DW-1:0] rdDataA,
  // Read port B.
  input  wire [AW-1:0] rdAddrB,
  output reg  [DW-1:0] rdDataB
);

  reg [DW-1:0] cells [0:(1<<AW)-1];

  always @(posedge sys_clk) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
    rdDataA <= cells[rdAddrA];
    rdDataB <= cells[rdAddrB];
  end

endmodule // mmsm_mem

// [testbench/mmsm_map_monitor.sv]
// Port-level checker for the memory-map block, bound to its top module.
`timescale 1ns/100ps
module mmsm_map_monitor #(
  parameter PW = 8
) (
  // Clock and reset.
  input wire          sys_clk,
  input wire          nrst,
  // Instruction pointer and stack.
  input wire          ipStep,
  input wire          ipJump,
  input wire          ipCall,
  input wire          ipRet,
  input wire [11:0]   instructionPointer,
  input wire [2:0]    stackLevel,
  // Data space.
  input wire [7:0]    dataAddr,
  input wire          dataWrEn,
  input wire          dataRdEn,
  input wire [7:0]    dataWrData,
  input wire [7:0]    dataRdData,
  // Program memory readback and protection.
  input wire          extRdEn,
  input wire [7:0]    extRdData,
  input wire          extRdValid,
  input wire          extRefused,
  input wire          eraseBusy,
  input wire          readProtected,
  // Register faces.
  input wire [PW-1:0] portAPinOut,
  input wire [PW-1:0] portAPinOe,
  input wire [PW-1:0] portAPullUp,
  input wire [7:0]    interruptOption,
  input wire [7:0]    timerPrescale,
  input wire [7:0]    timerDowncount
);
  ////////////////////////////////////////////////
  // Erase lengths are far beyond a repetition, so busy cycles are counted.
  reg [12:0] busyCnt_reg;
  reg [2:0]  sinceRst_reg;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busyCnt_reg  <= 13'h0000;
      sinceRst_reg <= 3'h0;
    end else begin
      busyCnt_reg  <= eraseBusy ? busyCnt_reg + 13'h0001 : 13'h0000;
      sinceRst_reg <= (sinceRst_reg == 3'h7) ? 3'h7 : sinceRst_reg + 3'h1;
    end
  end
  ////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  timer_reset_a:
    assert property ($rose(nrst) |-> timerPrescale == 8'h7F &&
      timerDowncount == 8'hFF) else $error("timer reset value wrong");
  port_reset_a:
    assert property ($rose(nrst) |-> portAPinOe == '0 && portAPullUp == '1)
      else $error("port pins not input with pull-up after reset");
  drive_no_pull_a:
    assert property ((portAPinOe & portAPullUp) == '0)
      else $error("pull-up active on a driven pin");
  port_write_a:
    assert property (dataWrEn && dataAddr == 8'hC0 |=>
      portAPinOut == $past(dataWrData)) else $error("port data write lost");
  intopt_write_a:
    assert property (dataWrEn && dataAddr == 8'hC8 |=>
      interruptOption == $past(dataWrData)) else $error("option write lost");
  hidden_read_a:
    assert property (dataRdEn && dataAddr inside {8'hC2, 8'hC8, 8'hC9} |=>
      dataRdData == 8'h00) else $error("hidden location read nonzero");
  ip_step_a:
    assert property (ipStep && !ipJump && !ipCall && !ipRet |=>
      instructionPointer == $past(instructionPointer) + 12'h001)
      else $error("instruction pointer step wrong");
  stack_push_a:
    assert property (ipCall && stackLevel < 3'd6 |=>
      stackLevel == $past(stackLevel) + 3'd1) else $error("push level wrong");
  stack_full_a:
    assert property (ipCall && stackLevel == 3'd6 |=> stackLevel == 3'd6)
      else $error("stack level beyond six");
  protect_refuse_a:
    assert property (extRdEn && readProtected |=> extRefused && !extRdValid
      && extRdData == 8'h00) else $error("protected readback not refused");
  window_clash_a:
    assert property (extRdEn && dataRdEn && dataAddr[7:6] == 2'b01 |=>
      extRefused) else $error("readback during window read not refused");
  erase_length_a:
    assert property ($fell(eraseBusy) |-> busyCnt_reg == 13'h1000)
      else $error("erase did not span whole program memory");
  unlock_erase_a:
    assert property ($fell(readProtected) && sinceRst_reg == 3'h7 |->
      $past(eraseBusy) && !eraseBusy) else $error("protection cleared early");
endmodule // mmsm_map_monitor

bind mmsm_map mmsm_map_monitor #(.PW(PW)) mmsm_map_monitor_inst (
  .sys_clk(sys_clk), .nrst(nrst), .ipStep(ipStep), .ipJump(ipJump),
  .ipCall(ipCall), .ipRet(ipRet), .instructionPointer(instructionPointer),
  .stackLevel(stackLevel), .dataAddr(dataAddr), .dataWrEn(dataWrEn),
  .dataRdEn(dataRdEn), .dataWrData(dataWrData), .dataRdData(dataRdData),
  .extRdEn(extRdEn), .extRdData(extRdData), .extRdValid(extRdValid),
  .extRefused(extRefused), .eraseBusy(eraseBusy),
  .readProtected(readProtected), .portAPinOut(portAPinOut),
  .portAPinOe(portAPinOe), .portAPullUp(portAPullUp),
  .interruptOption(interruptOption), .timerPrescale(timerPrescale),
  .timerDowncount(timerDowncount));

// [testbench/tb_top.sv]
// Self-checking bench for the memory-map block, driven at its ports.
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk, nrst, ipStep, ipJump, ipCall, ipRet;
  logic [11:0] ipTarget, extAddr, progAddr;
  logic [7:0]  dataAddr, dataWrData, progWrData, portAPinIn, portBPinIn;
  logic [7:0]  converterResult, converterStatus;
  logic        dataWrEn, dataRdEn, extRdEn, progWrEn;
  logic        protectSet, optReadProtect, eraseStart;
  wire  [11:0] instructionPointer;
  wire  [7:0]  fetchData, dataRdData, extRdData;
  wire  [2:0]  stackLevel;
  wire         extRdValid, extRefused, eraseBusy, readProtected;
  wire  [7:0]  portAPinOut, portAPinOe, portAPullUp;
  wire  [7:0]  portBPinOut, portBPinOe, portBPullUp;
  wire  [7:0]  converterControl, interruptOption, timerPrescale;
  wire  [7:0]  timerDowncount, timerStatusControl, watchdogCounter;
  int          badCount, comparisons, cycles, n, i;
  // Address and expected value after reset; pins read through on inputs.
  logic [7:0]  rstAddr [15] = '{8'hC0, 8'hC1, 8'hC4, 8'hC5, 8'hCC, 8'hCD,
    8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD8, 8'hC2, 8'hC8, 8'hD5};
  logic [7:0]  rstVal [15] = '{8'hA5, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h5A, 8'h40, 8'h7F, 8'hFF, 8'h00, 8'hFE, 8'h00, 8'h00, 8'h00};
  logic [7:0]  memAddr [3] = '{8'h10, 8'h81, 8'hFF};

  mmsm_map #(.PW(8)) mmsm_map_inst (
    .sys_clk(sys_clk), .nrst(nrst), .ipStep(ipStep), .ipJump(ipJump),
    .ipCall(ipCall), .ipRet(ipRet), .ipTarget(ipTarget),
    .instructionPointer(instructionPointer), .fetchData(fetchData),
    .stackLevel(stackLevel), .dataAddr(dataAddr), .dataWrEn(dataWrEn),
    .dataRdEn(dataRdEn), .dataWrData(dataWrData), .dataRdData(dataRdData),
    .extRdEn(extRdEn), .extAddr(extAddr), .extRdData(extRdData),
    .extRdValid(extRdValid), .extRefused(extRefused), .progWrEn(progWrEn),
    .progAddr(progAddr), .progWrData(progWrData), .protectSet(protectSet),
    .optReadProtect(optReadProtect), .eraseStart(eraseStart),
    .eraseBusy(eraseBusy), .readProtected(readProtected),
    .portAPinIn(portAPinIn), .portAPinOut(portAPinOut),
    .portAPinOe(portAPinOe), .portAPullUp(portAPullUp),
    .portBPinIn(portBPinIn), .portBPinOut(portBPinOut),
    .portBPinOe(portBPinOe), .portBPullUp(portBPullUp),
    .converterResult(converterResult), .converterStatus(converterStatus),
    .converterControl(converterControl), .interruptOption(interruptOption),
    .timerPrescale(timerPrescale), .timerDowncount(timerDowncount),
    .timerStatusControl(timerStatusControl),
    .watchdogCounter(watchdogCounter));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stopTest;
    if (badCount == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Every request is raised at one falling edge and dropped at the next.
  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    dataAddr = a;
    dataWrData = d;
    dataWrEn = 1'b1;
    @(negedge sys_clk);
    dataWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge sys_clk);
    dataAddr = a;
    dataRdEn = 1'b1;
    @(negedge sys_clk);
    dataRdEn = 1'b0;
    chk($sformatf("data %h", a), {8'h00, dataRdData}, {8'h00, exp});
  endtask
  task automatic ipOp(input logic [3:0] op, input logic [11:0] t);
    @(negedge sys_clk);
    {ipCall, ipRet, ipJump, ipStep} = op;
    ipTarget = t;
    @(negedge sys_clk);
    {ipCall, ipRet, ipJump, ipStep} = 4'h0;
  endtask
  task automatic progWr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {progWrEn, progAddr, progWrData} = {1'b1, a, d};
    @(negedge sys_clk);
    progWrEn = 1'b0;
  endtask
  // The window read may share the cycle, which the block must refuse.
  task automatic ext(input logic [11:0] a, input logic win,
                     input logic [9:0] exp);
    @(negedge sys_clk);
    extAddr = a;
    extRdEn = 1'b1;
    dataAddr = 8'h45;
    dataRdEn = win;
    @(negedge sys_clk);
    extRdEn = 1'b0;
    dataRdEn = 1'b0;
    chk("readback", {6'h00, extRdValid, extRefused, extRdData}, {6'h00, exp});
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      badCount++;
      stopTest();
    end
  end
  ////////////////////////////////////////////////
  initial begin
    {nrst, ipStep, ipJump, ipCall, ipRet, dataWrEn, dataRdEn} = 7'h00;
    {extRdEn, progWrEn, protectSet, optReadProtect, eraseStart} = 5'h00;
    {ipTarget, extAddr, progAddr} = 36'h0_0000_0000;
    {dataAddr, dataWrData, progWrData} = 24'h00_0000;
    portAPinIn = 8'hA5;
    portBPinIn = 8'h3C;
    converterResult = 8'h5A;
    converterStatus = 8'h40;
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    chk("ip reset", {4'h0, instructionPointer}, 16'h0FFF);
    chk("cnv ctrl", {8'h00, converterControl}, 16'h0040);
    chk("timer regs", {timerPrescale, timerDowncount}, 16'h7FFF);
    chk("tsc", {8'h00, timerStatusControl}, 16'h0000);
    chk("wdg", {8'h00, watchdogCounter}, 16'h00FE);
    // Pin synchronisers need two edges before a port read shows the pins.
    repeat (2) @(negedge sys_clk);
    for (i = 0; i < 15; i++)
      rd(rstAddr[i], rstVal[i]);
    wr(8'hC0, 8'h3C);
    wr(8'hC4, 8'hFF);
    chk("pull a", {portAPinOe, portAPullUp}, 16'hFF00);
    rd(8'hC0, 8'h3C);
    wr(8'hCD, 8'h0F);
    chk("pull b", {8'h00, portBPullUp}, 16'h00F0);
    wr(8'hC5, 8'hF0);
    wr(8'hC1, 8'h5A);
    chk("port b", {portBPinOe, portBPinOut}, 16'hF05A);
    rd(8'hC1, 8'h5C);
    wr(8'hC2, 8'h55);
    rd(8'hC2, 8'h00);
    wr(8'hD2, 8'h12);
    rd(8'hD2, 8'h12);
    wr(8'hC8, 8'h5A);
    chk("int option", {8'h00, interruptOption}, 16'h005A);
    rd(8'hC8, 8'h00);
    wr(8'hD1, 8'hFF);
    rd(8'hD1, 8'hCF);
    for (i = 0; i < 3; i++) begin
      wr(memAddr[i], 8'h60 + 8'(i));
      rd(memAddr[i], 8'h60 + 8'(i));
    end
    progWr(12'h0C5, 8'hA7);
    wr(8'hC9, 8'h03);
    rd(8'h45, 8'hA7);
    ext(12'h0C5, 1'b0, 10'h2A7);
    ext(12'h0C5, 1'b1, 10'h100);
    @(negedge sys_clk);
    protectSet = 1'b1;
    @(negedge sys_clk);
    protectSet = 1'b0;
    ext(12'h0C5, 1'b0, 10'h100);
    @(negedge sys_clk);
    eraseStart = 1'b1;
    @(negedge sys_clk);
    eraseStart = 1'b0;
    for (n = 0; n < 5000 && eraseBusy === 1'b1; n++)
      @(negedge sys_clk);
    chk("erase cycles", n[15:0], 16'h1000);
    chk("protect", {15'h0000, readProtected}, 16'h0000);
    rd(8'h45, 8'hFF);
    ext(12'h0C5, 1'b0, 10'h2FF);
    progWr(12'hABC, 8'h3D);
    ipOp(4'h1, 12'h000);
    chk("ip wrap", {4'h0, instructionPointer}, 16'h0000);
    ipOp(4'h2, 12'hABC);
    chk("ip jump", {4'h0, instructionPointer}, 16'h0ABC);
    @(negedge sys_clk);
    chk("fetch", {8'h00, fetchData}, 16'h003D);
    ipOp(4'h2, 12'h000);
    for (i = 0; i < 7; i++)
      ipOp(4'h8, 12'h100);
    chk("level", {13'h0000, stackLevel}, 16'h0006);
    for (i = 0; i < 6; i++)
      ipOp(4'h4, 12'h000);
    chk("ip pop", {4'h0, instructionPointer}, 16'h0101);
    ipOp(4'h4, 12'hABC);
    chk("ip empty", {4'h0, instructionPointer}, 16'h0000);
    stopTest();
  end
endmodule // tb_top
